// [adcst_ctrl.sv]
// converter sequencing, trigger control and register slave
`timescale 1ns/1ps
`default_nettype none
`include "adcst_defs.svh"
// Overview of operation
// - sequential mode: channels sampled and converted one after another, one sample each
// - simultaneous mode: all channels sampled on one clock, then converted in turn
// - channel count picks one, two or four holds; every result goes to buffer
// - four-bit sequences-per-interrupt field sets sequences before interrupt, 1 to 16
// - split mode writes one 8-word half, switching halves at each interrupt
// - alternate select clear: only multiplexer A inputs are used
// - alternate select set: A and B inputs used on alternating sequences
// - scan enabled: first hold steps across A inputs marked in scan mask
// - scan runs low to high, restarts after interrupt, surplus inputs unused
// - trigger source select picks the event that ends sampling, starts conversion
// - source 000: trigger when software clears sample control
// - source 111: trigger after auto sample time conversion clocks of sampling
// - auto start with sample time one gives thirteen clocks per conversion
// - other sources spend extra conversion clocks synchronising the event
// - clearing converter on aborts conversion; buffer keeps last complete value
// - abort wins over an auto start in the same cycle
// - after abort: sequential goes to next channel, simultaneous to next group
// - each conversion lasts twelve conversion clocks
// - conversion clock is half instruction cycle times divider plus one
// - internal oscillator select takes conversion clock from the oscillator pin
// - setting sample control starts acquisition
// - after the programmed sequences are stored, set interrupt flag and done
module adcst_ctrl
   import adcst_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register bus
   input wire adcst_avm_req_t avm_req,
   output var adcst_avm_rsp_t avm_rsp,
   // converter side
   input wire logic [9:0] conv_data,
   input wire logic rc_clk_pin,
   input wire logic [5:0] ext_trigger,
   output var adcst_conv_t conv,
   // status
   output var logic conversion_interrupt_flag,
   output var logic done
);
   adcst_ctrl_t s;
   adcst_ctrl_t next_s;
   logic req, wr_en, sw_clear_sample_control, trig, store, seq_end;
   logic rc_edge;
   logic [5:0] tr_edge;
   logic [1:0] last;
   logic [4:0] pick, pick_nx;
   logic [3:0] scan_idx;
   logic [31:0] wd;
   logic [4:0] a;
   logic [3:0] mem_waddr;
   logic [9:0] mem_rdata;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [1:0] last_ch(input logic [1:0] chps);
      return (chps == 2'h0) ? 2'h0 : ((chps == 2'h1) ? 2'h1 : 2'h3);
   endfunction

   // lowest set mask bit at or above pos; bit 4 of the result marks a hit
   function automatic logic [4:0] first_from(input logic [15:0] mask, input logic [4:0] pos);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 15; i >= 0; i--)
      begin
         if (mask[i] && (5'(i) >= pos))
         begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] reg_read(input adcst_ctrl_t r, input logic [3:0] idx);
      logic [31:0] v;
      v = 32'h0;
      case (idx)
         `ADCST_OFS_CTRL1:
         begin
            v[`ADCST_C1_ON] = r.on;
            v[`ADCST_C1_SAMPLE_CONTROL] = r.sample_control;
            v[`ADCST_C1_ASAM] = r.asam;
            v[`ADCST_C1_SIMULTANEOUS_SAMPLE_SELECT] = r.simultaneous_sample_select;
            v[`ADCST_C1_SSRC +: 3] = r.ssrc;
            v[`ADCST_C1_DONE] = r.done;
            v[`ADCST_C1_IF] = r.intf;
         end
         `ADCST_OFS_CTRL2:
         begin
            v[`ADCST_C2_ALTERNATE_MUX_SELECT] = r.alternate_mux_select;
            v[`ADCST_C2_BUFFER_SPLIT_MODE] = r.buffer_split_mode;
            v[`ADCST_C2_SMPI +: 4] = r.smpi;
            v[`ADCST_C2_HALF] = r.half;
            v[`ADCST_C2_CHPS +: 2] = r.chps;
            v[`ADCST_C2_CH0_SCAN_ENABLE] = r.ch0_scan_enable;
         end
         `ADCST_OFS_CTRL3:
         begin
            v[`ADCST_C3_ADCS +: 6] = r.adcs;
            v[`ADCST_C3_INTERNAL_RC_CLOCK_SELECT] = r.internal_rc_clock_select;
            v[`ADCST_C3_AUTO_SAMPLE_TIME +: 5] = r.auto_sample_time;
         end
         `ADCST_OFS_SCAN: v[15:0] = r.scan_sel;
         `ADCST_OFS_MUX:
         begin
            v[`ADCST_MX_A +: 4] = r.mux_a;
            v[`ADCST_MX_B +: 4] = r.mux_b;
         end
         default: v = 32'h0;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_s = s;
      a = avm_req.address;
      wd = avm_req.writedata;
      req = avm_req.read | avm_req.write;
      wr_en = (s.bus_stage == 2'h2) && avm_req.write;
      sw_clear_sample_control = 1'b0;
      trig = 1'b0;
      store = 1'b0;
      seq_end = 1'b0;
      last = last_ch(s.chps);
      // two wait cycles give the buffer its registered read
      unique case (s.bus_stage)
         2'h0: if (req) next_s.bus_stage = 2'h1;
         2'h1:
         begin
            next_s.bus_stage = 2'h2;
            next_s.rsp.waitrequest = 1'b0;
            next_s.rsp.readdata = a[`ADCST_BUF_BIT] ? {22'h0, mem_rdata} : reg_read(s, a[3:0]);
         end
         default:
         begin
            next_s.bus_stage = 2'h0;
            next_s.rsp.waitrequest = 1'b1;
         end
      endcase
      if (wr_en && !a[`ADCST_BUF_BIT])
      begin
         case (a[3:0])
            `ADCST_OFS_CTRL1:
            begin
               next_s.on = wd[`ADCST_C1_ON];
               next_s.sample_control = wd[`ADCST_C1_SAMPLE_CONTROL];
               next_s.asam = wd[`ADCST_C1_ASAM];
               next_s.simultaneous_sample_select = wd[`ADCST_C1_SIMULTANEOUS_SAMPLE_SELECT];
               next_s.ssrc = wd[`ADCST_C1_SSRC +: 3];
               if (!wd[`ADCST_C1_DONE]) next_s.done = 1'b0;
               if (!wd[`ADCST_C1_IF]) next_s.intf = 1'b0;
               sw_clear_sample_control = s.sample_control & ~wd[`ADCST_C1_SAMPLE_CONTROL];
            end
            `ADCST_OFS_CTRL2:
            begin
               next_s.alternate_mux_select = wd[`ADCST_C2_ALTERNATE_MUX_SELECT];
               next_s.buffer_split_mode = wd[`ADCST_C2_BUFFER_SPLIT_MODE];
               next_s.smpi = wd[`ADCST_C2_SMPI +: 4];
               next_s.chps = wd[`ADCST_C2_CHPS +: 2];
               next_s.ch0_scan_enable = wd[`ADCST_C2_CH0_SCAN_ENABLE];
            end
            `ADCST_OFS_CTRL3:
            begin
               next_s.adcs = wd[`ADCST_C3_ADCS +: 6];
               next_s.internal_rc_clock_select = wd[`ADCST_C3_INTERNAL_RC_CLOCK_SELECT];
               next_s.auto_sample_time = wd[`ADCST_C3_AUTO_SAMPLE_TIME +: 5];
            end
            `ADCST_OFS_SCAN: next_s.scan_sel = wd[15:0];
            `ADCST_OFS_MUX:
            begin
               next_s.mux_a = wd[`ADCST_MX_A +: 4];
               next_s.mux_b = wd[`ADCST_MX_B +: 4];
            end
            default: next_s.on = next_s.on;
         endcase
      end
      // pin synchronisers; edges only from the second stage on
      next_s.rc_s1 = rc_clk_pin;
      next_s.rc_s2 = s.rc_s1;
      next_s.rc_q = s.rc_s2;
      next_s.tr_s1 = ext_trigger;
      next_s.tr_s2 = s.tr_s1;
      next_s.tr_q = s.tr_s2;
      rc_edge = s.rc_s2 & ~s.rc_q;
      tr_edge = s.tr_s2 & ~s.tr_q;
      next_s.tad = 1'b0;
      if (s.internal_rc_clock_select)
      begin
         next_s.div_cnt = 6'h00;
         next_s.tad = rc_edge;
      end
      else if (s.div_cnt >= s.adcs)
      begin
         next_s.div_cnt = 6'h00;
         next_s.tad = 1'b1;
      end
      else
      begin
         next_s.div_cnt = s.div_cnt + 6'h01;
      end
      pick = first_from(s.scan_sel, s.scan_pos);
      if (!pick[4])
      begin
         pick = first_from(s.scan_sel, 5'h00);
      end
      scan_idx = pick[3:0];
      if (!next_s.on)
      begin
         if (s.st == st_convert)
         begin
            next_s.ch = (s.simultaneous_sample_select || s.ch == last) ? 2'h0 : s.ch + 2'h1;
         end
         next_s.st = st_idle;
         next_s.sample_control = 1'b0;
         next_s.tad_cnt = 5'h00;
         next_s.trig_pend = 1'b0;
      end
      else
      begin
         unique case (s.st)
            st_idle:
            begin
               if (next_s.sample_control)
               begin
                  next_s.st = st_sample;
                  next_s.tad_cnt = 5'h00;
                  next_s.trig_pend = 1'b0;
               end
            end
            st_sample:
            begin
               if (s.ssrc == `ADCST_SSRC_SW)
               begin
                  trig = sw_clear_sample_control;
               end
               else if (s.ssrc == `ADCST_SSRC_AUTO)
               begin
                  if (s.tad)
                  begin
                     next_s.tad_cnt = s.tad_cnt + 5'h01;
                     trig = (s.tad_cnt + 5'h01) >= s.auto_sample_time;
                  end
               end
               else
               begin
                  // event waits for a conversion clock
                  if (tr_edge[s.ssrc - 3'h1]) next_s.trig_pend = 1'b1;
                  trig = s.trig_pend & s.tad;
               end
               if (trig)
               begin
                  next_s.st = st_convert;
                  next_s.sample_control = 1'b0;
                  next_s.tad_cnt = 5'h00;
                  next_s.trig_pend = 1'b0;
                  if (s.ch0_scan_enable && !s.use_b && s.ch == 2'h0)
                  begin
                     next_s.scan_pos = {1'b0, scan_idx} + 5'h01;
                  end
               end
               else if (!next_s.sample_control && s.ssrc != `ADCST_SSRC_SW)
               begin
                  next_s.st = st_idle;
               end
            end
            st_convert:
            begin
               if (s.tad)
               begin
                  next_s.tad_cnt = s.tad_cnt + 5'h01;
                  if (s.tad_cnt == `ADCST_CONV_TAD - 5'h01)
                  begin
                     store = 1'b1;
                     next_s.tad_cnt = 5'h00;
                     next_s.wptr = s.wptr + 4'h1;
                     if (s.ch != last)
                     begin
                        next_s.ch = s.ch + 2'h1;
                        if (!s.simultaneous_sample_select)
                        begin
                           next_s.st = st_sample;
                           next_s.sample_control = 1'b1;
                        end
                     end
                     else
                     begin
                        seq_end = 1'b1;
                        next_s.ch = 2'h0;
                        if (s.alternate_mux_select) next_s.use_b = ~s.use_b;
                        if (s.seq_cnt == s.smpi)
                        begin
                           next_s.seq_cnt = 4'h0;
                           next_s.wptr = 4'h0;
                           next_s.scan_pos = 5'h00;
                           next_s.done = 1'b1;
                           next_s.intf = 1'b1;
                           if (s.buffer_split_mode) next_s.half = ~s.half;
                        end
                        else
                        begin
                           next_s.seq_cnt = s.seq_cnt + 4'h1;
                        end
                        next_s.st = s.asam ? st_sample : st_idle;
                        next_s.sample_control = s.asam;
                     end
                  end
               end
            end
         endcase
      end
      // only mux A when alternation off
      if (!next_s.alternate_mux_select) next_s.use_b = 1'b0;
      next_s.conv.sampling = (next_s.st == st_sample);
      next_s.conv.converting = (next_s.st == st_convert);
      next_s.conv.sh_channel = next_s.ch;
      next_s.conv.use_mux_b = next_s.use_b;
      // scanned first hold input
      // from the next state, so the input lines up with the sampling flag
      pick_nx = first_from(next_s.scan_sel, next_s.scan_pos);
      if (!pick_nx[4])
      begin
         pick_nx = first_from(next_s.scan_sel, 5'h00);
      end
      next_s.conv.ch0_input = next_s.use_b ? next_s.mux_b : next_s.mux_a;
      if (next_s.ch0_scan_enable && !next_s.use_b)
      begin
         next_s.conv.ch0_input = pick_nx[3:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         s <= '0;
         s.rsp.waitrequest <= `ADCST_WAIT_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // every result stored, split halves addressed by the half bit
   assign mem_waddr = s.buffer_split_mode ? {s.half, s.wptr[2:0]} : s.wptr;

   adcst_result_mem #(.WIDTH(10), .DEPTH(16), .AW(4)) u_mem (
      .clk(clk),
      .we(store),
      .waddr(mem_waddr),
      .wdata(conv_data),
      .raddr(a[3:0]),
      .rdata(mem_rdata)
   );

   assign avm_rsp = s.rsp;
   assign conv = s.conv;
   assign conversion_interrupt_flag = s.intf;
   assign done = s.done;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence bus_taken_s;
      req && s.bus_stage == 2'h0;
   endsequence
   sequence bus_answer_s;
      s.rsp.waitrequest ##1 s.rsp.waitrequest ##1 !s.rsp.waitrequest ##1 s.rsp.waitrequest;
   endsequence
   sequence int_event_s;
      seq_end && s.seq_cnt == s.smpi && next_s.on;
   endsequence

   bus_answer_a: assert property (bus_taken_s |-> bus_answer_s)
      else $error("bus answer timing wrong");
   abort_no_store_a: assert property (s.st == st_convert && !next_s.on |-> !store ##1 s.st == st_idle)
      else $error("aborted conversion stored");
   abort_first_a: assert property (s.st == st_sample && s.ssrc == `ADCST_SSRC_AUTO && s.tad && !next_s.on |=> !s.conv.converting)
      else $error("auto start beat abort");
   sw_trigger_a: assert property (s.st == st_sample && s.ssrc == `ADCST_SSRC_SW && sw_clear_sample_control && next_s.on |=> s.conv.converting)
      else $error("software trigger missed");
   auto_trigger_a: assert property (s.st == st_sample && s.ssrc == `ADCST_SSRC_AUTO && !s.tad |=> s.st != st_convert)
      else $error("auto trigger off a conversion clock");
   seq_resample_a: assert property (store && !s.simultaneous_sample_select && s.ch != last && next_s.on |=> s.st == st_sample && s.sample_control)
      else $error("sequential channel not resampled");
   simul_chain_a: assert property (store && s.simultaneous_sample_select && s.ch != last && next_s.on |=> s.st == st_convert ##0 s.tad_cnt == 5'h00)
      else $error("simultaneous chain broken");
   int_set_a: assert property (int_event_s |=> s.intf && s.done && s.seq_cnt == 4'h0)
      else $error("interrupt not raised");
   half_swap_a: assert property ((int_event_s and s.buffer_split_mode) |=> s.half != $past(s.half))
      else $error("buffer half not switched");
   mux_a_only_a: assert property (!s.alternate_mux_select |=> !s.conv.use_mux_b)
      else $error("mux B used with alternation off");
   conv_len_a: assert property (store |-> s.tad && s.tad_cnt == 5'h0B && s.st == st_convert)
      else $error("conversion length wrong");
   abort_resume_a: assert property (s.st == st_convert && !next_s.on && !s.simultaneous_sample_select
      |=> s.ch == (($past(s.ch) == $past(last)) ? 2'h0 : $past(s.ch) + 2'h1))
      else $error("abort resume channel wrong");
endmodule // adcst_ctrl
`default_nettype wire

// [adcst_defs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef ADCST_DEFS_SVH
`define ADCST_DEFS_SVH
// word offsets inside the register page (address bit 4 clear)
`define ADCST_OFS_CTRL1 4'h0
`define ADCST_OFS_CTRL2 4'h1
`define ADCST_OFS_CTRL3 4'h2
`define ADCST_OFS_SCAN 4'h3
`define ADCST_OFS_MUX 4'h4
// address bit that selects the result buffer page
`define ADCST_BUF_BIT 4
// control register one
`define ADCST_C1_ON 0
`define ADCST_C1_SAMPLE_CONTROL 1
`define ADCST_C1_ASAM 2
`define ADCST_C1_SIMULTANEOUS_SAMPLE_SELECT 3
`define ADCST_C1_SSRC 4
`define ADCST_C1_DONE 8
`define ADCST_C1_IF 9
// control register two
`define ADCST_C2_ALTERNATE_MUX_SELECT 0
`define ADCST_C2_BUFFER_SPLIT_MODE 1
`define ADCST_C2_SMPI 2
`define ADCST_C2_HALF 7
`define ADCST_C2_CHPS 8
`define ADCST_C2_CH0_SCAN_ENABLE 10
// control register three
`define ADCST_C3_ADCS 0
`define ADCST_C3_INTERNAL_RC_CLOCK_SELECT 7
`define ADCST_C3_AUTO_SAMPLE_TIME 8
// multiplexer select register
`define ADCST_MX_A 0
`define ADCST_MX_B 8
// trigger source codes
`define ADCST_SSRC_SW 3'h0
`define ADCST_SSRC_AUTO 3'h7
// reset values
`define ADCST_WAIT_RST 1'b1
// conversion length in conversion clocks
`define ADCST_CONV_TAD 5'h0C
`endif

// [adcst_pkg.sv]
// types shared by the sequencer and its testbench
package adcst_pkg;
   typedef enum logic [1:0] {st_idle, st_sample, st_convert} adcst_state_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [31:0] writedata;
   } adcst_avm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } adcst_avm_rsp_t;

   typedef struct packed {
      logic sampling;
      logic converting;
      logic [1:0] sh_channel;
      logic use_mux_b;
      logic [3:0] ch0_input;
   } adcst_conv_t;

   typedef struct packed {
      adcst_avm_rsp_t rsp;
      logic [1:0] bus_stage;
      logic on, sample_control, asam, simultaneous_sample_select;
      logic [2:0] ssrc;
      logic done, intf, alternate_mux_select, buffer_split_mode, ch0_scan_enable, internal_rc_clock_select;
      logic [3:0] smpi;
      logic [1:0] chps;
      logic [5:0] adcs;
      logic [4:0] auto_sample_time;
      logic [15:0] scan_sel;
      logic [3:0] mux_a, mux_b;
      adcst_state_t st;
      logic [5:0] div_cnt;
      logic tad, trig_pend, half, use_b;
      logic [4:0] tad_cnt, scan_pos;
      logic [1:0] ch;
      logic [3:0] seq_cnt, wptr;
      logic rc_s1, rc_s2, rc_q;
      logic [5:0] tr_s1, tr_s2, tr_q;
      adcst_conv_t conv;
   } adcst_ctrl_t;
endpackage

// [adcst_result_mem.sv]
// result buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module adcst_result_mem
   import adcst_pkg::*;
#(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16,
   parameter int AW = 4
)
(
   // clock
   input wire logic clk,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read port
   input wire logic [AW-1:0] raddr,
   output var logic [WIDTH-1:0] rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rdata;
   } adcst_mem_t;

   adcst_mem_t s;
   adcst_mem_t next_s;

   // no reset: a result word is only meaningful once written
   always_comb
   begin
      next_s = s;
      if (we)
      begin
         next_s.mem[waddr] = wdata;
      end
      next_s.rdata = s.mem[raddr];
   end

   always_ff @(posedge clk)
   begin
      s <= next_s;
   end

   assign rdata = s.rdata;
endmodule // adcst_result_mem
`default_nettype wire

// [adc_sequence_trigger_control_tb.sv]
// self-checking testbench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adcst_defs.svh"
module adc_sequence_trigger_control_tb
   import adcst_pkg::*;
();
   // clock and reset
   logic clk;
   logic rstn;
   // bus and converter side
   adcst_avm_req_t req;
   adcst_avm_rsp_t rsp;
   logic [9:0] conv_data;
   logic rc_clk_pin;
   logic [5:0] ext_trigger;
   adcst_conv_t conv;
   logic intf;
   logic done;
   // bench state
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic [4:0] smp;

   adcst_ctrl u_dut (.clk(clk), .rstn(rstn), .avm_req(req), .avm_rsp(rsp),
      .conv_data(conv_data), .rc_clk_pin(rc_clk_pin), .ext_trigger(ext_trigger),
      .conv(conv), .conversion_interrupt_flag(intf), .done(done));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // result encodes mux set and input seen while sampling, plus the hold worked
   always @(posedge clk)
   begin
      if (conv.sampling)
         smp <= {conv.use_mux_b, conv.ch0_input};
      conv_data <= {smp, 3'h0, conv.sh_channel};
      rc_clk_pin <= cyc[1];
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // request held until waitrequest is sampled low; sampled before edge updates
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      req <= '{read: !wr, write: wr, address: a, writedata: d};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rsp.waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
         error_cnt++;
      rd = rsp.readdata;
      req <= '{default: '0};
   endtask

   task automatic buf_chk(input int i, input logic [31:0] e, input string m);
      bus(1'b0, 5'(16 + i), 32'h0);
      check(rd, e, m);
   endtask

   function automatic logic [31:0] dv(input logic b, input logic [3:0] inp, input logic [1:0] ch);
      return {22'h0, b, inp, 3'h0, ch};
   endfunction

   // back-to-back channels may keep converting high, so some waits use the flag
   task automatic wait_conv(input int k);
      int n;
      int seen;
      logic last;
      n = 0;
      seen = 0;
      last = conv.converting;
      while (seen < k && n < 2000)
      begin
         @(posedge clk);
         n++;
         if (last === 1'b1 && conv.converting === 1'b0)
            seen++;
         last = conv.converting;
      end
      check(seen, k, "conversion wait");
   endtask

   task automatic wait_flag();
      int n;
      n = 0;
      while (intf !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic setup(input logic [31:0] c2, c3, scan, mux);
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h0);
      bus(1'b1, `ADCST_OFS_CTRL2, c2);
      bus(1'b1, `ADCST_OFS_CTRL3, c3);
      bus(1'b1, `ADCST_OFS_SCAN, scan);
      bus(1'b1, `ADCST_OFS_MUX, mux);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      bus(1'b1, `ADCST_OFS_CTRL2, 32'hFFFF);
      bus(1'b0, `ADCST_OFS_CTRL2, 32'h0);
      check(rd, 32'h0000073F, "ctrl2 writable bits");
      bus(1'b0, 5'h05, 32'h0);
      check(rd, 32'h0, "unmapped read");
   endtask

   // auto start, one tick per two clocks, two sequences per interrupt
   task automatic t_auto();
      int w;
      int p;
      setup(32'h4, 32'h0101, 32'h0, 32'h3);
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h77);
      w = 0;
      while (conv.converting !== 1'b1 && w < 500)
      begin
         @(posedge clk);
         w++;
      end
      w = 0;
      while (conv.converting === 1'b1 && w < 500)
      begin
         @(posedge clk);
         w++;
      end
      check(w, 24, "conversion length");
      check(intf, 1'b0, "flag after one sequence");
      p = 0;
      while (conv.converting !== 1'b1 && p < 500)
      begin
         @(posedge clk);
         p++;
      end
      check(w + p, 26, "sample plus convert period");
      wait_conv(1);
      repeat (2) @(posedge clk);
      check(intf, 1'b1, "flag after two sequences");
      check(done, 1'b1, "done after two sequences");
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h0);
      buf_chk(0, dv(1'b0, 4'h3, 2'h0), "auto word0");
   endtask

   task automatic t_soft();
      setup(32'h100, 32'h0, 32'h0, 32'h5);
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h0B);
      repeat (4) @(posedge clk);
      check(conv.sampling, 1'b1, "sampling started");
      check(conv.converting, 1'b0, "no trigger yet");
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h09);
      wait_flag();
      check(done, 1'b1, "done simultaneous");
      buf_chk(0, dv(1'b0, 4'h5, 2'h0), "sim word0");
      bus(1'b0, 5'h11, 32'h0);
      check(rd[1:0], 2'h1, "sim word1 hold");
   endtask

   // aborted result must not overwrite the value from the previous run
   task automatic t_abort();
      int n;
      setup(32'h0, 32'h0, 32'h0, 32'h7);
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h03);
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h01);
      n = 0;
      while (conv.converting !== 1'b1 && n < 500)
      begin
         @(posedge clk);
         n++;
      end
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h0);
      repeat (30) @(posedge clk);
      check(conv.converting, 1'b0, "abort stops");
      check(intf, 1'b0, "abort no flag");
      buf_chk(0, dv(1'b0, 4'h5, 2'h0), "abort keeps word0");
   endtask

   task automatic t_split();
      setup(32'h3, 32'h100, 32'h0, 32'h0503);
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h77);
      wait_conv(1);
      bus(1'b0, `ADCST_OFS_CTRL2, 32'h0);
      check(rd[7], 1'b1, "half toggled");
      wait_conv(1);
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h0);
      buf_chk(0, dv(1'b0, 4'h3, 2'h0), "split first half");
      buf_chk(8, dv(1'b1, 4'h5, 2'h0), "split second half");
   endtask

   // three inputs selected, two samples per interrupt: the highest stays unused
   task automatic t_scan();
      setup(32'h404, 32'h100, 32'h0212, 32'h0);
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h77);
      wait_conv(4);
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h0);
      buf_chk(0, dv(1'b0, 4'h1, 2'h0), "scan first");
      buf_chk(1, dv(1'b0, 4'h4, 2'h0), "scan second");
   endtask

   task automatic t_ext();
      setup(32'h0, 32'h80, 32'h0, 32'h6);
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h13);
      repeat (20) @(posedge clk);
      check(conv.converting, 1'b0, "waits for pin");
      ext_trigger <= 6'h01;
      @(posedge clk);
      check(conv.converting, 1'b0, "pin synchronised");
      wait_flag();
      ext_trigger <= 6'h00;
      check(intf, 1'b1, "oscillator clocked conversion");
      bus(1'b1, `ADCST_OFS_CTRL1, 32'h0);
      buf_chk(0, dv(1'b0, 4'h6, 2'h0), "ext word0");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rstn = 1'b0;
      req = '{default: '0};
      ext_trigger = 6'h00;
      conv_data = 10'h000;
      rc_clk_pin = 1'b0;
      smp = 5'h00;
      repeat (12) @(posedge clk);
      check(rsp.waitrequest, 1'b1, "wait in reset");
      rstn <= 1'b1;
      t_regs();
      t_auto();
      t_soft();
      t_abort();
      t_split();
      t_scan();
      t_ext();
      complete_run();
   end
endmodule // adc_sequence_trigger_control_tb
`default_nettype wire
